/* shared/aod_pkg.sv */
// Shared constants for the overrange detector: register map, fields, timing
package aod_pkg;
  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int SAMPLE_W = 12;
  localparam int THR_W = 8;
  localparam int HOLD_SET_W = 3;
  localparam int HOLD_CNT_W = 11;
  localparam int WIN_CNT_W = 8;
  localparam int IQ_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CHAN = 2;
  localparam int NUM_EVT = 4;

  // ----------------------------------------------------------------------
  // Timing: flag hold is HOLD_BASE device-clock cycles times 2**setting
  // ----------------------------------------------------------------------
  localparam logic [HOLD_CNT_W-1:0] HOLD_BASE = 11'h008;
  localparam logic [WIN_CNT_W-1:0] WIN_BASE = 8'h01;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_THRESH = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_LIVE = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int THR_HIGH_LSB = 0;
  localparam int THR_LOW_LSB = 8;
  localparam int CTRL_HOLD_LSB = 0;
  localparam int CTRL_EMBED_BIT = 3;
  localparam int CTRL_FGCAL_BIT = 4;
  localparam int LIVE_CALBUSY_BIT = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [THR_W-1:0] HIGH_THR_RST = 8'hFF;
  localparam logic [THR_W-1:0] LOW_THR_RST = 8'hFF;
  localparam logic [HOLD_SET_W-1:0] HOLD_SET_RST = 3'h0;
  localparam logic [NUM_EVT-1:0] MASK_RST = 4'h0;
endpackage : aod_pkg

/* design/aod_chan_det.sv */
// One channel of the overrange detector: magnitude, compare, hold, window
`timescale 1ns/10ps
module aod_chan_det (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sample stream
  input wire logic sampleValid,
  input wire logic [aod_pkg::SAMPLE_W-1:0] sample,
  // Configuration
  input wire logic [aod_pkg::THR_W-1:0] highThresh,
  input wire logic [aod_pkg::THR_W-1:0] lowThresh,
  input wire logic [aod_pkg::HOLD_SET_W-1:0] holdSetting,
  // Results: index 0 high-level threshold, index 1 low-level threshold
  output logic [1:0] hitNow,
  output logic [1:0] pinFlag,
  output logic [1:0] winFlag
);

  typedef struct packed {
    logic [1:0][aod_pkg::HOLD_CNT_W-1:0] holdCnt;
    logic [1:0] flag;
    logic [aod_pkg::WIN_CNT_W-1:0] winCnt;
    logic [1:0] acc;
    logic [1:0] winFlag;
  } aod_chan_st_t;

  aod_chan_st_t st_q;
  aod_chan_st_t st_d;
  logic [aod_pkg::THR_W-1:0] mag;
  logic [aod_pkg::HOLD_CNT_W-1:0] holdLen;
  logic [aod_pkg::WIN_CNT_W-1:0] winLen;
  logic winLast;

  // Saturating absolute value, upper eight bits kept for the compare
  function automatic logic [aod_pkg::THR_W-1:0] magUpper(
    input logic [aod_pkg::SAMPLE_W-1:0] s
  );
    logic [aod_pkg::SAMPLE_W-2:0] m;
    m = s[aod_pkg::SAMPLE_W-2:0];
    if (s[aod_pkg::SAMPLE_W-1]) begin
      // Most negative code has no positive twin, so clamp instead of wrap
      if (m == '0) begin
        m = '1;
      end else begin
        m = (~m) + 1'b1;
      end
    end
    return m[aod_pkg::SAMPLE_W-2 -: aod_pkg::THR_W];
  endfunction : magUpper

  // Next-state logic for compare, hold stretch and monitoring window
  always_comb begin
    st_d = st_q;
    mag = magUpper(sample);
    hitNow[0] = sampleValid && (mag >= highThresh);
    hitNow[1] = sampleValid && (mag >= lowThresh);
    holdLen = aod_pkg::HOLD_BASE << holdSetting;
    winLen = aod_pkg::WIN_BASE << holdSetting;
    // Greater-or-equal keeps a shrunken window from running past its end
    winLast = (st_q.winCnt >= winLen - 1'b1);
    for (int k = 0; k < 2; k++) begin
      // Flag stands holdLen cycles counted from the last hit
      if (hitNow[k]) begin
        st_d.holdCnt[k] = holdLen;
      end else if (st_q.holdCnt[k] != '0) begin
        st_d.holdCnt[k] = st_q.holdCnt[k] - 1'b1;
      end
      st_d.flag[k] = hitNow[k] || (st_q.holdCnt[k] > 1);
      if (sampleValid) begin
        if (winLast) begin
          st_d.winFlag[k] = st_q.acc[k] | hitNow[k];
          st_d.acc[k] = 1'b0;
        end else begin
          st_d.acc[k] = st_q.acc[k] | hitNow[k];
        end
      end
    end
    if (sampleValid) begin
      st_d.winCnt = winLast ? '0 : st_q.winCnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pinFlag = st_q.flag;
  assign winFlag = st_q.winFlag;

endmodule : aod_chan_det

/* design/aod_overrange.sv */
// Overrange detector top: register port, two channels, pins, embedding
//
// Notes on behaviour
// - Each 12-bit sample is turned into a magnitude whose upper 8 bits are compared with two thresholds.
// - Both channels use the same pair of thresholds; there is no per-channel setting.
// - The magnitude saturates, so -2048 reads as 2047 and -2032 and +2032 both compare as 254.
// - A flag is 1 when the 8-bit magnitude is at or above its threshold, else 0.
// - Channel A and channel B each drive a high-level and a low-level flag pin.
// - A pin flag stays high 8 times 2 to the hold setting cycles after the last hit.
// - In complex mode I samples carry the high-level flag as LSB and Q samples the low-level flag.
// - An embedded flag is high if its channel hit within a window of 2 to the hold setting samples.
// - Foreground calibration halts sample comparison; background calibration does not.
`timescale 1ns/10ps
module aod_overrange (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [aod_pkg::ADDR_W-1:0] regAddr,
  input wire logic [aod_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [aod_pkg::DATA_W-1:0] regRdData,
  // Converted samples, one per channel per valid cycle
  input wire logic sampleValid,
  input wire logic [aod_pkg::SAMPLE_W-1:0] sampleA,
  input wire logic [aod_pkg::SAMPLE_W-1:0] sampleB,
  // Calibration engine status
  input wire logic calBusy,
  // Complex decimated samples in
  input wire logic iqValid,
  input wire logic [aod_pkg::IQ_W-1:0] iSampleA,
  input wire logic [aod_pkg::IQ_W-1:0] qSampleA,
  input wire logic [aod_pkg::IQ_W-1:0] iSampleB,
  input wire logic [aod_pkg::IQ_W-1:0] qSampleB,
  // Complex samples out with embedded flags
  output logic iqOutValid,
  output logic [aod_pkg::IQ_W-1:0] iOutA,
  output logic [aod_pkg::IQ_W-1:0] qOutA,
  output logic [aod_pkg::IQ_W-1:0] iOutB,
  output logic [aod_pkg::IQ_W-1:0] qOutB,
  // Flag pins
  output logic chanAHighLevelFlag,
  output logic chanALowLevelFlag,
  output logic chanBHighLevelFlag,
  output logic chanBLowLevelFlag,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [aod_pkg::THR_W-1:0] highThresh;
    logic [aod_pkg::THR_W-1:0] lowThresh;
    logic [aod_pkg::HOLD_SET_W-1:0] holdSetting;
    logic embedEn;
    logic fgCalMode;
    logic [aod_pkg::NUM_EVT-1:0] status;
    logic [aod_pkg::NUM_EVT-1:0] mask;
    logic [aod_pkg::DATA_W-1:0] rdData;
    logic irq;
    logic iqValid;
    logic [aod_pkg::IQ_W-1:0] iA;
    logic [aod_pkg::IQ_W-1:0] qA;
    logic [aod_pkg::IQ_W-1:0] iB;
    logic [aod_pkg::IQ_W-1:0] qB;
  } aod_top_st_t;

  aod_top_st_t st_q;
  aod_top_st_t st_d;
  // Reset image as a constant, so the async branch loads no logic output
  localparam aod_top_st_t ST_RST = '{
    highThresh: aod_pkg::HIGH_THR_RST,
    lowThresh: aod_pkg::LOW_THR_RST,
    holdSetting: aod_pkg::HOLD_SET_RST,
    mask: aod_pkg::MASK_RST,
    default: '0
  };

  logic sampleAccept;
  logic [aod_pkg::NUM_CHAN-1:0][aod_pkg::SAMPLE_W-1:0] chanSample;
  logic [aod_pkg::NUM_CHAN-1:0][1:0] chanHit;
  logic [aod_pkg::NUM_CHAN-1:0][1:0] chanPin;
  logic [aod_pkg::NUM_CHAN-1:0][1:0] chanWin;
  logic [aod_pkg::NUM_EVT-1:0] evt;
  logic [aod_pkg::NUM_EVT-1:0] live;

  // ----------------------------------------------------------------------
  // Sample gating
  // ----------------------------------------------------------------------
  // A foreground run takes the cores offline, so its output is not data
  assign sampleAccept = sampleValid && !(st_q.fgCalMode && calBusy);
  assign chanSample[0] = sampleA;
  assign chanSample[1] = sampleB;

  // ----------------------------------------------------------------------
  // Channel detectors
  // ----------------------------------------------------------------------
  // One detector per channel, both fed from the same threshold registers
  for (genvar c = 0; c < aod_pkg::NUM_CHAN; c++) begin : g_chan
    aod_chan_det u_det (
      .clk(clk),
      .rst(rst),
      .sampleValid(sampleAccept),
      .sample(chanSample[c]),
      .highThresh(st_q.highThresh),
      .lowThresh(st_q.lowThresh),
      .holdSetting(st_q.holdSetting),
      .hitNow(chanHit[c]),
      .pinFlag(chanPin[c]),
      .winFlag(chanWin[c])
    );
  end

  // Event and live vectors: A high, A low, B high, B low
  assign evt = {chanHit[1][1], chanHit[1][0], chanHit[0][1], chanHit[0][0]};
  assign live = {chanPin[1][1], chanPin[1][0], chanPin[0][1], chanPin[0][0]};

  // ----------------------------------------------------------------------
  // Register port, interrupt and sample embedding
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rdData = '0;
    // Writes land at the edge, so the next sample already sees them
    if (regWr) begin
      unique case (regAddr)
        aod_pkg::REG_THRESH: begin
          st_d.highThresh =
            regWrData[aod_pkg::THR_HIGH_LSB +: aod_pkg::THR_W];
          st_d.lowThresh =
            regWrData[aod_pkg::THR_LOW_LSB +: aod_pkg::THR_W];
        end
        aod_pkg::REG_CTRL: begin
          st_d.holdSetting =
            regWrData[aod_pkg::CTRL_HOLD_LSB +: aod_pkg::HOLD_SET_W];
          st_d.embedEn = regWrData[aod_pkg::CTRL_EMBED_BIT];
          st_d.fgCalMode = regWrData[aod_pkg::CTRL_FGCAL_BIT];
        end
        aod_pkg::REG_MASK: begin
          st_d.mask = regWrData[aod_pkg::NUM_EVT-1:0];
        end
        default: begin
        end
      endcase
    end
    // Read data stands only in the cycle after the strobe
    if (regRd) begin
      unique case (regAddr)
        aod_pkg::REG_THRESH: begin
          st_d.rdData[aod_pkg::THR_HIGH_LSB +: aod_pkg::THR_W] =
            st_q.highThresh;
          st_d.rdData[aod_pkg::THR_LOW_LSB +: aod_pkg::THR_W] =
            st_q.lowThresh;
        end
        aod_pkg::REG_CTRL: begin
          st_d.rdData[aod_pkg::CTRL_HOLD_LSB +: aod_pkg::HOLD_SET_W] =
            st_q.holdSetting;
          st_d.rdData[aod_pkg::CTRL_EMBED_BIT] = st_q.embedEn;
          st_d.rdData[aod_pkg::CTRL_FGCAL_BIT] = st_q.fgCalMode;
        end
        aod_pkg::REG_STATUS: begin
          st_d.rdData[aod_pkg::NUM_EVT-1:0] = st_q.status;
        end
        aod_pkg::REG_MASK: begin
          st_d.rdData[aod_pkg::NUM_EVT-1:0] = st_q.mask;
        end
        aod_pkg::REG_LIVE: begin
          st_d.rdData[aod_pkg::NUM_EVT-1:0] = live;
          st_d.rdData[aod_pkg::LIVE_CALBUSY_BIT] = calBusy;
        end
        default: begin
        end
      endcase
    end
    // Sticky events: a hit in the clearing read's cycle survives the clear
    if (regRd && regAddr == aod_pkg::REG_STATUS) begin
      st_d.status = evt;
    end else begin
      st_d.status = st_q.status | evt;
    end
    st_d.irq = |(st_d.status & st_q.mask);
    // Complex samples: swap the LSB for the windowed flag when enabled
    st_d.iqValid = iqValid;
    if (iqValid) begin
      if (st_q.embedEn) begin
        st_d.iA = {iSampleA[aod_pkg::IQ_W-1:1], chanWin[0][0]};
        st_d.qA = {qSampleA[aod_pkg::IQ_W-1:1], chanWin[0][1]};
        st_d.iB = {iSampleB[aod_pkg::IQ_W-1:1], chanWin[1][0]};
        st_d.qB = {qSampleB[aod_pkg::IQ_W-1:1], chanWin[1][1]};
      end else begin
        st_d.iA = iSampleA;
        st_d.qA = qSampleA;
        st_d.iB = iSampleB;
        st_d.qB = qSampleB;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Flag pins come straight from the detectors' hold flip-flops
  assign chanAHighLevelFlag = chanPin[0][0];
  assign chanALowLevelFlag = chanPin[0][1];
  assign chanBHighLevelFlag = chanPin[1][0];
  assign chanBLowLevelFlag = chanPin[1][1];
  assign regRdData = st_q.rdData;
  assign irq = st_q.irq;
  assign iqOutValid = st_q.iqValid;
  assign iOutA = st_q.iA;
  assign qOutA = st_q.qA;
  assign iOutB = st_q.iB;
  assign qOutB = st_q.qB;

endmodule : aod_overrange

/* tb/aod_overrange_asserts.sv */
// Port checker for the overrange detector, bound to the top module
`timescale 1ns/10ps
module aod_overrange_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [aod_pkg::ADDR_W-1:0] regAddr,
  input wire logic [aod_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [aod_pkg::DATA_W-1:0] regRdData,
  // Samples and calibration
  input wire logic sampleValid,
  input wire logic [aod_pkg::SAMPLE_W-1:0] sampleA,
  input wire logic [aod_pkg::SAMPLE_W-1:0] sampleB,
  input wire logic calBusy,
  // Complex path, channel A
  input wire logic iqValid,
  input wire logic [aod_pkg::IQ_W-1:0] iSampleA,
  input wire logic [aod_pkg::IQ_W-1:0] qSampleA,
  input wire logic iqOutValid,
  input wire logic [aod_pkg::IQ_W-1:0] iOutA,
  input wire logic [aod_pkg::IQ_W-1:0] qOutA,
  // Flag pins and interrupt
  input wire logic chanAHighLevelFlag,
  input wire logic chanALowLevelFlag,
  input wire logic chanBHighLevelFlag,
  input wire logic chanBLowLevelFlag,
  input wire logic irq
);
  logic [7:0] thrHi_q, thrLo_q;
  logic [2:0] hold_q;
  logic fg_q, emb_q;
  logic [3:0] msk_q, stat_q, hit, flg;
  logic [11:0] cnt_q [4];
  logic [11:0] len_q [4];

  // Saturating magnitude, so the most negative code cannot wrap to zero
  function automatic logic [7:0] cmp8(input logic [11:0] s);
    logic [11:0] m;
    m = s[11] ? 12'h000 - s : s;
    if (m[11]) m = 12'h7FF;
    return m[10:3];
  endfunction : cmp8

  assign flg = {chanBLowLevelFlag, chanBHighLevelFlag,
                chanALowLevelFlag, chanAHighLevelFlag};

  // Hits of the sample taken at this edge, none in foreground cal
  always_comb begin
    hit = 4'h0;
    if (sampleValid && !(fg_q && calBusy)) begin
      hit[0] = cmp8(sampleA) >= thrHi_q;
      hit[1] = cmp8(sampleA) >= thrLo_q;
      hit[2] = cmp8(sampleB) >= thrHi_q;
      hit[3] = cmp8(sampleB) >= thrLo_q;
    end
  end

  // Shadow settings, sticky status and cycles since each last hit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thrHi_q <= 8'hFF;
      thrLo_q <= 8'hFF;
      hold_q <= 3'h0;
      fg_q <= 1'b0;
      emb_q <= 1'b0;
      msk_q <= 4'h0;
      stat_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        cnt_q[i] <= 12'hFFF;
        len_q[i] <= 12'h008;
      end
    end else begin
      if (regWr && regAddr == aod_pkg::REG_THRESH) begin
        thrHi_q <= regWrData[7:0];
        thrLo_q <= regWrData[15:8];
      end
      if (regWr && regAddr == aod_pkg::REG_CTRL) begin
        hold_q <= regWrData[2:0];
        emb_q <= regWrData[3];
        fg_q <= regWrData[4];
      end
      if (regWr && regAddr == aod_pkg::REG_MASK) msk_q <= regWrData[3:0];
      stat_q <= (regRd && regAddr == aod_pkg::REG_STATUS ? 4'h0 : stat_q)
                | hit;
      for (int i = 0; i < 4; i++) begin
        if (hit[i]) begin
          cnt_q[i] <= 12'h000;
          len_q[i] <= 12'h008 << hold_q;
        end else if (cnt_q[i] != 12'hFFF) begin
          cnt_q[i] <= cnt_q[i] + 12'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_rdIdle;
    !$past(regRd) |-> regRdData == 32'h0;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data outside read slot");

  for (genvar i = 0; i < 4; i++) begin : g_flag
    property p_flag;
      flg[i] == (cnt_q[i] < len_q[i]);
    endproperty
    a_flag: assert property (p_flag)
      else $error("flag pin level wrong");
  end

  property p_irq;
    irq == |(stat_q & $past(msk_q));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt level wrong");

  property p_rdStatus;
    regRd && regAddr == aod_pkg::REG_STATUS
      |=> regRdData == {28'h0, $past(stat_q)};
  endproperty
  a_rdStatus: assert property (p_rdStatus)
    else $error("status read wrong");

  property p_rdThresh;
    regRd && regAddr == aod_pkg::REG_THRESH
      |=> regRdData == {16'h0, $past(thrLo_q), $past(thrHi_q)};
  endproperty
  a_rdThresh: assert property (p_rdThresh)
    else $error("threshold read wrong");

  property p_iqUpper;
    iqValid |=> iqOutValid && iOutA[15:1] == $past(iSampleA[15:1])
      && qOutA[15:1] == $past(qSampleA[15:1]);
  endproperty
  a_iqUpper: assert property (p_iqUpper)
    else $error("complex upper bits wrong");

  property p_embedOff;
    iqValid && !emb_q |=> iOutA[0] == $past(iSampleA[0])
      && qOutA[0] == $past(qSampleA[0]);
  endproperty
  a_embedOff: assert property (p_embedOff)
    else $error("passthrough lsb wrong");

  property p_iqHold;
    !iqValid |=> !iqOutValid && $stable(iOutA) && $stable(qOutA);
  endproperty
  a_iqHold: assert property (p_iqHold)
    else $error("complex output moved");
endmodule : aod_overrange_asserts

bind aod_overrange aod_overrange_asserts u_chk (.clk, .rst, .regAddr,
  .regWrData, .regWr, .regRd, .regRdData, .sampleValid, .sampleA,
  .sampleB, .calBusy, .iqValid, .iSampleA, .qSampleA, .iqOutValid,
  .iOutA, .qOutA, .chanAHighLevelFlag, .chanALowLevelFlag,
  .chanBHighLevelFlag, .chanBLowLevelFlag, .irq);

/* tb/aod_gain_ctl.sv */
// Downstream gain-control model fed by the four flag pins
`timescale 1ns/10ps
module aod_gain_ctl #(
  parameter logic [7:0] HIGH_THR = 8'hE4,
  parameter logic [7:0] LOW_THR = 8'h40
) (
  // Flag pins
  input wire logic aHigh,
  input wire logic aLow,
  input wire logic bHigh,
  input wire logic bLow,
  // Gain decisions
  output logic gainDown,
  output logic gainUp
);
  // Both channel pins of a threshold are merged, as in single-channel use
  assign gainDown = aHigh | bHigh;
  assign gainUp = !(aLow | bLow);
endmodule : aod_gain_ctl

/* tb/aod_overrange_tb_top.sv */
// Self-checking bench for the overrange detector
`timescale 1ns/10ps
module aod_overrange_tb_top;
  logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic sampleValid = 1'b0, calBusy = 1'b0, iqValid = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData, rdv;
  logic [11:0] sampleA = 12'h000, sampleB = 12'h000;
  logic [15:0] iSampleA = 16'h0, qSampleA = 16'h0;
  logic [15:0] iSampleB = 16'h0, qSampleB = 16'h0;
  logic [15:0] iOutA, qOutA, iOutB, qOutB;
  logic iqOutValid, irq, gainDown, gainUp;
  logic chanAHighLevelFlag, chanALowLevelFlag;
  logic chanBHighLevelFlag, chanBLowLevelFlag;
  int n_mismatch = 0, checks = 0, cyc = 0;
  wire [3:0] flg = {chanBLowLevelFlag, chanBHighLevelFlag,
                    chanALowLevelFlag, chanAHighLevelFlag};

  aod_overrange dut (.clk, .rst, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .sampleValid, .sampleA, .sampleB, .calBusy, .iqValid,
    .iSampleA, .qSampleA, .iSampleB, .qSampleB, .iqOutValid, .iOutA,
    .qOutA, .iOutB, .qOutB, .chanAHighLevelFlag, .chanALowLevelFlag,
    .chanBHighLevelFlag, .chanBLowLevelFlag, .irq);
  aod_gain_ctl gain (.aHigh(chanAHighLevelFlag), .aLow(chanALowLevelFlag),
    .bHigh(chanBHighLevelFlag), .bLow(chanBLowLevelFlag),
    .gainDown, .gainUp);

  // Clock of 100 ns period
  always #50 clk = ~clk;

  // Hang guard: the tests need some 2250 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------------
  // Bus, stimulus and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    rdv = regRdData;
  endtask : rd

  task automatic samp(input logic [11:0] a, b);
    @(posedge clk);
    sampleValid <= 1'b1;
    sampleA <= a;
    sampleB <= b;
    @(posedge clk);
    sampleValid <= 1'b0;
    @(negedge clk);
  endtask : samp

  task automatic iq(input logic [15:0] i, q);
    @(posedge clk);
    iqValid <= 1'b1;
    {iSampleA, qSampleA, iSampleB, qSampleB} <= {i, q, i, q};
    @(posedge clk);
    iqValid <= 1'b0;
    @(negedge clk);
  endtask : iq

  task automatic test_reset();
    wr(aod_pkg::REG_STATUS, 32'hFFFFFFFF);
    rd(aod_pkg::REG_THRESH);
    chk("thresh", rdv, 32'h0000FFFF);
    rd(aod_pkg::REG_CTRL);
    chk("ctrl", rdv, 32'h0);
    rd(aod_pkg::REG_STATUS);
    chk("status", rdv, 32'h0);
    rd(8'h14);
    chk("unmapped", rdv, 32'h0);
    $display("test reset done");
  endtask : test_reset

  // Magnitude table: two bits per channel, low-level over high-level
  task automatic test_table();
    logic [11:0] smp [6] = '{12'h7FF, 12'h7F0, 12'h000, 12'h810,
                             12'h800, 12'h7EF};
    logic [1:0] e [6] = '{2'h3, 2'h1, 2'h0, 2'h1, 2'h3, 2'h0};
    wr(aod_pkg::REG_THRESH, 32'h0000FFFE);
    for (int i = 0; i < 6; i++) begin
      samp(smp[i], smp[5-i]);
      chk("flags", {28'h0, flg}, {28'h0, e[5-i], e[i]});
      repeat (10) @(posedge clk);
    end
    $display("test table done");
  endtask : test_table

  task automatic test_hold();
    int n;
    for (int s = 0; s < 8; s++) begin
      wr(aod_pkg::REG_CTRL, s);
      samp(12'h7FF, 12'h000);
      n = 0;
      while (chanAHighLevelFlag === 1'b1 && n < 2000) begin
        n++;
        @(negedge clk);
      end
      chk("hold", n, 32'h8 << s);
    end
    $display("test hold done");
  endtask : test_hold

  task automatic test_irq();
    wr(aod_pkg::REG_CTRL, 32'h0);
    wr(aod_pkg::REG_MASK, 32'h1);
    rd(aod_pkg::REG_STATUS);
    samp(12'h7FF, 12'h000);
    @(negedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(aod_pkg::REG_STATUS);
    chk("status", rdv, 32'h3);
    @(negedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(aod_pkg::REG_MASK, 32'h4);
    samp(12'h7FF, 12'h000);
    repeat (2) @(negedge clk);
    chk("masked irq", {31'h0, irq}, 32'h0);
    rd(aod_pkg::REG_STATUS);
    chk("status", rdv, 32'h3);
    $display("test irq done");
  endtask : test_irq

  task automatic test_cal();
    wr(aod_pkg::REG_CTRL, 32'h10);
    calBusy <= 1'b1;
    repeat (10) @(posedge clk);
    samp(12'h7FF, 12'h7FF);
    chk("fg flags", {28'h0, flg}, 32'h0);
    wr(aod_pkg::REG_CTRL, 32'h0);
    samp(12'h7FF, 12'h7FF);
    chk("bg flags", {28'h0, flg}, 32'hF);
    rd(aod_pkg::REG_LIVE);
    chk("live", rdv, 32'h1F);
    @(posedge clk);
    calBusy <= 1'b0;
    $display("test cal done");
  endtask : test_cal

  task automatic test_embed();
    wr(aod_pkg::REG_THRESH, {16'h0, gain.LOW_THR, gain.HIGH_THR});
    iq(16'h1235, 16'h5679);
    chk("pass i", {16'h0, iOutA}, 32'h1235);
    wr(aod_pkg::REG_CTRL, 32'h8);
    samp(12'h7F0, 12'h100);
    chk("down", {31'h0, gainDown}, 32'h1);
    chk("up", {31'h0, gainUp}, 32'h0);
    iq(16'h1234, 16'h5678);
    chk("iA", {16'h0, iOutA}, 32'h1235);
    chk("qA", {16'h0, qOutA}, 32'h5679);
    chk("iB", {16'h0, iOutB}, 32'h1234);
    chk("qB", {16'h0, qOutB}, 32'h5678);
    // A quiet one-sample window first, so the hit below must set the bit
    samp(12'h000, 12'h000);
    wr(aod_pkg::REG_CTRL, 32'h9);
    samp(12'h7F0, 12'h000);
    samp(12'h000, 12'h000);
    iq(16'h1234, 16'h5678);
    chk("win hit", {16'h0, iOutA}, 32'h1235);
    samp(12'h000, 12'h000);
    samp(12'h000, 12'h000);
    iq(16'h1235, 16'h5679);
    chk("win quiet", {16'h0, qOutA}, 32'h5678);
    $display("test embed done");
  endtask : test_embed

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_table();
    test_hold();
    test_irq();
    test_cal();
    test_embed();
    wrap_up();
  end
endmodule : aod_overrange_tb_top
